/* File: design/timer_compare_pwm_channels.sv */
// Two capture/compare channels with a small counter, Avalon-MM slave.
// Assumes timer_input pins are asynchronous; all else runs on sys_clk.
// Functional notes
// - PWM input: one input feeds two captures, rising and falling edge.
// - Slave mode 100 with trigger 101 resets the counter on each input 1 edge selected by channel 1 polarity.
// - Role 01 maps input 1 to channel 1; role 10 maps it to channel 2.
// - Only the channel 1 filtered input reaches the slave controller.
// - Output role: mode 101 forces reference high, mode 100 forces low.
// - Forced modes still compare and set the match flag and interrupt.
// - Pin equals reference, inverted when polarity bit is set.
// - On match: 000 hold, 001 active, 010 inactive, 011 toggle.
// - Every match sets the flag, in center mode only in a flagged direction; with enable set it raises interrupt.
// - Compare is evaluated on every counter value.
// - Preload off: compare write acts at once; on: at update event.
// - Mode 110 is PWM1, 111 PWM2; compare sets duty, period the cycle.
// - In PWM mode counter and shadow compare are compared every clock.
// - Center select 01 flags down only, 10 up only, 11 both.
// - Hardware owns direction in center mode; software writes ignored.
// - Counter write 0 or period sets direction; above period keeps it.
// - PWM1 up: high while counter below compare; 0 keeps low.
// - PWM1 down: low while counter above compare, else high.
// - Shadow at or above period: next cycle uses 0, no event at zero.
// - Capture flag clears by software write or by reading capture.
// - Update events only at a wrap with repetition counter zero, by request, or by trigger reset.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`include "timer_compare_pwm_channels_cfg.svh"
module timer_compare_pwm_channels #(
   parameter int CNT_W = 16,
   parameter int REP_W = 8
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire timer_pwm_pkg::chan_pair_t timer_input,
   output timer_pwm_pkg::chan_pair_t compare_output_pin,
   output timer_pwm_pkg::chan_pair_t channelIrq
);
   import timer_pwm_pkg::*;

   logic counterEnable_reg;
   logic direction_reg;
   logic [1:0] centerAlign_reg;
   logic reloadPreload_reg;
   logic [2:0] slaveMode_reg;
   logic [2:0] triggerSource_reg;
   logic [1:0] matchFlag_reg;
   logic [1:0] interruptEnable_reg;
   logic [15:0] modeCfg_reg;
   logic [7:0] outputCfg_reg;
   logic [CNT_W-1:0] counterValue_reg;
   logic [CNT_W-1:0] periodLimit_reg;
   logic [CNT_W-1:0] periodShadow_reg;
   logic [REP_W-1:0] repLoad_reg;
   logic [REP_W-1:0] repCount_reg;
   logic [CNT_W-1:0] compareValue_reg [0:1];
   logic [CNT_W-1:0] compareShadow_reg [0:1];
   logic [1:0] zeroSkip_reg;
   logic [1:0] reference_reg;
   logic [1:0] inSync1_reg;
   logic [1:0] inSync2_reg;
   logic [1:0] inSync3_reg;
   logic [1:0] inFilt_reg;
   logic [1:0] inPrev_reg;
   logic [31:0] readMux;
   logic [31:0] beMask;
   logic [31:0] wEff;
   logic writeFire;
   logic readFire;
   logic swUpdate;
   logic trigEdge;
   logic wrap;
   logic updateEvt;
   logic cntWrite;
   logic dirOk;
   logic [1:0] rise;
   logic [1:0] fall;
   logic fi1Edge1;
   logic fi1Edge2;
   logic fi2Edge2;
   logic [1:0] captureEvt;
   logic [1:0] matchHit;
   logic [1:0] matchEvt;
   channel_role_t role [0:1];
   compare_mode_t ocMode [0:1];
   logic [1:0] preloadEn;
   logic [1:0] chEnable;
   logic [1:0] chPolarity;

   // Next reference level from compare mode and the counter
   function automatic logic refNext(input compare_mode_t m, input logic cur,
         input logic hit, input logic dn, input logic [CNT_W-1:0] c,
         input logic [CNT_W-1:0] s);
      logic pwm1;
      pwm1 = dn ? !(c > s) : (c < s);
      case (m)
         CMP_SET_ACTIVE: refNext = hit ? 1'b1 : cur;
         CMP_SET_INACTIVE: refNext = hit ? 1'b0 : cur;
         CMP_TOGGLE: refNext = hit ? !cur : cur;
         CMP_FORCE_LOW: refNext = 1'b0;
         CMP_FORCE_HIGH: refNext = 1'b1;
         CMP_PWM1: refNext = pwm1;
         CMP_PWM2: refNext = !pwm1;
         default: refNext = cur;
      endcase
   endfunction

   // Bus strobes: an access completes at the edge waitrequest is low
   assign writeFire = avs_write && !avs_waitrequest;
   assign readFire = avs_read && !avs_waitrequest;
   assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wEff = (avs_writedata & beMask) | (readMux & ~beMask);
   assign swUpdate = writeFire && avs_address == `ADDR_EVENT &&
      wEff[`EVENT_UPDATE_BIT];
   assign cntWrite = writeFire && avs_address == `ADDR_COUNTER;

   // Read multiplexer, unmapped addresses read zero
   always_comb
   begin
      readMux = 32'h0;
      case (avs_address)
         `ADDR_CTRL: readMux[4:0] = {reloadPreload_reg, centerAlign_reg,
            direction_reg, counterEnable_reg};
         `ADDR_SLAVE: readMux[6:0] = {triggerSource_reg, 1'b0,
            slaveMode_reg};
         `ADDR_STATUS: readMux[1:0] = matchFlag_reg;
         `ADDR_INTEN: readMux[1:0] = interruptEnable_reg;
         `ADDR_MODE: readMux[15:0] = modeCfg_reg;
         `ADDR_OUTCFG: readMux[7:0] = outputCfg_reg;
         `ADDR_COUNTER: readMux[CNT_W-1:0] = counterValue_reg;
         `ADDR_PERIOD: readMux[CNT_W-1:0] = periodLimit_reg;
         `ADDR_REPEAT: readMux[REP_W-1:0] = repLoad_reg;
         `ADDR_COMPARE1: readMux[CNT_W-1:0] = compareValue_reg[0];
         `ADDR_COMPARE2: readMux[CNT_W-1:0] = compareValue_reg[1];
         default: readMux = 32'h0;
      endcase
   end

   // One wait cycle per access, then the answer stands for one edge
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end
      else if ((avs_read || avs_write) && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? readMux : 32'h0;
      end
      else
         avs_waitrequest <= 1'b1;
   end

   // Control registers written by software
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         counterEnable_reg <= 1'b0;
         centerAlign_reg <= 2'h0;
         reloadPreload_reg <= 1'b0;
         slaveMode_reg <= 3'h0;
         triggerSource_reg <= 3'h0;
         interruptEnable_reg <= 2'h0;
         modeCfg_reg <= 16'h0;
         outputCfg_reg <= 8'h0;
         periodLimit_reg <= `PERIOD_RESET;
         repLoad_reg <= '0;
      end
      else if (writeFire)
      begin
         case (avs_address)
            `ADDR_CTRL:
            begin
               counterEnable_reg <= wEff[`CTRL_ENABLE_BIT];
               centerAlign_reg <= wEff[`CTRL_CENTER_LSB +: 2];
               reloadPreload_reg <= wEff[`CTRL_RELOAD_PRE_BIT];
            end
            `ADDR_SLAVE:
            begin
               slaveMode_reg <= wEff[`SLAVE_MODE_LSB +: 3];
               triggerSource_reg <= wEff[`SLAVE_TRIG_LSB +: 3];
            end
            `ADDR_INTEN: interruptEnable_reg <= wEff[1:0];
            `ADDR_MODE: modeCfg_reg <= wEff[15:0];
            `ADDR_OUTCFG: outputCfg_reg <= wEff[7:0];
            `ADDR_PERIOD: periodLimit_reg <= wEff[CNT_W-1:0];
            `ADDR_REPEAT: repLoad_reg <= wEff[REP_W-1:0];
            default: ;
         endcase
      end
   end

   // Input pins: three flops, a level counts once stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         inSync1_reg <= 2'h0;
         inSync2_reg <= 2'h0;
         inSync3_reg <= 2'h0;
         inFilt_reg <= 2'h0;
         inPrev_reg <= 2'h0;
      end
      else
      begin
         inSync1_reg <= timer_input;
         inSync2_reg <= inSync1_reg;
         inSync3_reg <= inSync2_reg;
         inFilt_reg <= (inSync2_reg & inSync3_reg) |
            (inFilt_reg & (inSync2_reg | inSync3_reg));
         inPrev_reg <= inFilt_reg;
      end
   end

   // Edges of the filtered inputs with each channel's polarity
   assign rise = inFilt_reg & ~inPrev_reg;
   assign fall = ~inFilt_reg & inPrev_reg;
   assign fi1Edge1 = chPolarity[0] ? fall[0] : rise[0];
   assign fi1Edge2 = chPolarity[1] ? fall[0] : rise[0];
   assign fi2Edge2 = chPolarity[1] ? fall[1] : rise[1];
   assign captureEvt[0] = chEnable[0] && role[0] == ROLE_DIRECT &&
      fi1Edge1;
   assign captureEvt[1] = chEnable[1] && ((role[1] == ROLE_CROSS &&
      fi1Edge2) || (role[1] == ROLE_DIRECT && fi2Edge2));
   // Only the channel 1 filtered edge can trigger the slave controller
   assign trigEdge = slaveMode_reg == `SLAVE_MODE_RESET &&
      triggerSource_reg == `TRIG_FILTERED_IN1 && fi1Edge1;

   // Counter wrap, repetition gate and the update event
   assign wrap = counterEnable_reg && (direction_reg ?
      counterValue_reg == '0 : counterValue_reg >= periodShadow_reg);
   assign updateEvt = swUpdate || trigEdge ||
      (wrap && repCount_reg == '0);
   assign dirOk = centerAlign_reg == 2'h0 ||
      centerAlign_reg == `CENTER_BOTH ||
      (centerAlign_reg == `CENTER_DOWN_ONLY && direction_reg) ||
      (centerAlign_reg == `CENTER_UP_ONLY && !direction_reg);

   // Counter value: software write, update or trigger reset, or count
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         counterValue_reg <= '0;
      else if (cntWrite)
         counterValue_reg <= wEff[CNT_W-1:0];
      else if (swUpdate || trigEdge)
         counterValue_reg <= (direction_reg && centerAlign_reg == 2'h0) ?
            periodShadow_reg : '0;
      else if (wrap && centerAlign_reg != 2'h0)
         counterValue_reg <= direction_reg ? CNT_W'(1) :
            periodShadow_reg - CNT_W'(1);
      else if (wrap)
         counterValue_reg <= direction_reg ? periodShadow_reg : '0;
      else if (counterEnable_reg)
         counterValue_reg <= direction_reg ?
            counterValue_reg - CNT_W'(1) : counterValue_reg + CNT_W'(1);
   end

   // Direction: hardware owns it in center-aligned counting
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         direction_reg <= 1'b0;
      else if (centerAlign_reg != 2'h0)
      begin
         if (cntWrite && wEff[CNT_W-1:0] == '0)
            direction_reg <= 1'b0;
         else if (cntWrite && wEff[CNT_W-1:0] == periodShadow_reg)
            direction_reg <= 1'b1;
         else if (!cntWrite && wrap)
            direction_reg <= !direction_reg;
      end
      else if (writeFire && avs_address == `ADDR_CTRL)
         direction_reg <= wEff[`CTRL_DIR_BIT];
   end

   // Period shadow and repetition counter
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         periodShadow_reg <= `PERIOD_RESET;
         repCount_reg <= '0;
      end
      else
      begin
         if (!reloadPreload_reg || updateEvt)
            periodShadow_reg <= periodLimit_reg;
         if (swUpdate || trigEdge)
            repCount_reg <= repLoad_reg;
         else if (wrap)
            repCount_reg <= (repCount_reg == '0) ? repLoad_reg :
               repCount_reg - REP_W'(1);
      end
   end

   // Per-channel compare, capture, flag and output logic
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         logic hitRaw;
         logic capRead;
         logic valWrite;
         assign role[ch] = channel_role_t'(
            modeCfg_reg[ch*`MODE_STRIDE + `MODE_ROLE_LSB +: 2]);
         assign ocMode[ch] = compare_mode_t'(
            modeCfg_reg[ch*`MODE_STRIDE + `MODE_OCM_LSB +: 3]);
         assign preloadEn[ch] =
            modeCfg_reg[ch*`MODE_STRIDE + `MODE_PRELOAD_BIT];
         assign chEnable[ch] =
            outputCfg_reg[ch*`OUTCFG_STRIDE + `OUTCFG_EN_BIT];
         assign chPolarity[ch] =
            outputCfg_reg[ch*`OUTCFG_STRIDE + `OUTCFG_POL_BIT];
         assign valWrite = writeFire &&
            avs_address == (ch == 0 ? `ADDR_COMPARE1 : `ADDR_COMPARE2);
         assign capRead = readFire && role[ch] != ROLE_OUTPUT &&
            avs_address == (ch == 0 ? `ADDR_COMPARE1 : `ADDR_COMPARE2);
         // Equality checked on every counter value, any output mode
         assign hitRaw = role[ch] == ROLE_OUTPUT && counterEnable_reg &&
            counterValue_reg == compareShadow_reg[ch];
         assign matchHit[ch] = hitRaw &&
            !(zeroSkip_reg[ch] && counterValue_reg == '0);
         assign matchEvt[ch] = matchHit[ch] && dirOk;

         // Capture latch and compare preload
         always_ff @(posedge sys_clk)
         begin
            if (!rst_b)
               compareValue_reg[ch] <= '0;
            else if (captureEvt[ch])
               compareValue_reg[ch] <= counterValue_reg;
            else if (valWrite)
               compareValue_reg[ch] <= wEff[CNT_W-1:0];
         end

         // Shadow compare: direct when preload off, else at update
         always_ff @(posedge sys_clk)
         begin
            if (!rst_b)
            begin
               compareShadow_reg[ch] <= '0;
               zeroSkip_reg[ch] <= 1'b0;
            end
            else if (!preloadEn[ch] && valWrite)
               compareShadow_reg[ch] <= wEff[CNT_W-1:0];
            else if (!preloadEn[ch])
               compareShadow_reg[ch] <= compareValue_reg[ch];
            else if (updateEvt)
            begin
               zeroSkip_reg[ch] <=
                  compareShadow_reg[ch] >= periodShadow_reg;
               compareShadow_reg[ch] <=
                  (compareShadow_reg[ch] >= periodShadow_reg) ?
                  '0 : compareValue_reg[ch];
            end
         end

         // Flag: set wins over a software or read clear
         always_ff @(posedge sys_clk)
         begin
            if (!rst_b)
               matchFlag_reg[ch] <= 1'b0;
            else if (matchEvt[ch] || captureEvt[ch])
               matchFlag_reg[ch] <= 1'b1;
            else if (capRead || (writeFire &&
                  avs_address == `ADDR_STATUS && !wEff[ch]))
               matchFlag_reg[ch] <= 1'b0;
         end

         // Reference waveform, output pin and interrupt request
         always_ff @(posedge sys_clk)
         begin
            if (!rst_b)
            begin
               reference_reg[ch] <= 1'b0;
               compare_output_pin[ch] <= 1'b0;
               channelIrq[ch] <= 1'b0;
            end
            else
            begin
               reference_reg[ch] <= refNext(ocMode[ch], reference_reg[ch],
                  matchHit[ch], direction_reg, counterValue_reg,
                  compareShadow_reg[ch]);
               compare_output_pin[ch] <= (role[ch] == ROLE_OUTPUT &&
                  chEnable[ch]) ? reference_reg[ch] ^ chPolarity[ch] :
                  1'b0;
               channelIrq[ch] <= matchFlag_reg[ch] &&
                  interruptEnable_reg[ch];
            end
         end
      end
   endgenerate

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_capture_latch;
      captureEvt[0] |=> compareValue_reg[0] == $past(counterValue_reg);
   endproperty
   a_capture_latch: assert property (p_capture_latch)
      else $error("capture did not latch counter");
   property p_reset_mode;
      trigEdge && !cntWrite |=> counterValue_reg == '0 ||
         direction_reg;
   endproperty
   a_reset_mode: assert property (p_reset_mode)
      else $error("trigger did not reset counter");
   property p_cross_map;
      role[1] == ROLE_CROSS && chEnable[1] && fi1Edge2 |=> matchFlag_reg[1];
   endproperty
   a_cross_map: assert property (p_cross_map)
      else $error("crosswise capture missed");
   property p_forced_high;
      ocMode[0] == CMP_FORCE_HIGH |=> reference_reg[0] ##1
         (compare_output_pin[0] == (chEnable[0] && role[0] == ROLE_OUTPUT &&
         $past(role[0]) == ROLE_OUTPUT && $past(chEnable[0])
         ? !$past(chPolarity[0]) : compare_output_pin[0]));
   endproperty
   a_forced_high: assert property (p_forced_high)
      else $error("forced high not applied");
   property p_forced_flag;
      ocMode[0] == CMP_FORCE_LOW && matchEvt[0] |=> matchFlag_reg[0] &&
         !reference_reg[0];
   endproperty
   a_forced_flag: assert property (p_forced_flag)
      else $error("forced mode lost flag or level");
   property p_pin_polarity;
      role[0] == ROLE_OUTPUT && chEnable[0] |=>
         compare_output_pin[0] == ($past(reference_reg[0]) ^
         $past(chPolarity[0]));
   endproperty
   a_pin_polarity: assert property (p_pin_polarity)
      else $error("pin does not follow reference");
   property p_toggle;
      ocMode[0] == CMP_TOGGLE && matchHit[0] |=>
         reference_reg[0] != $past(reference_reg[0]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle on match missed");
   property p_irq;
      matchEvt[0] && interruptEnable_reg[0] ##1 interruptEnable_reg[0]
         |=> channelIrq[0];
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");
   property p_pwm1_up;
      ocMode[0] == CMP_PWM1 && !direction_reg |=>
         reference_reg[0] == $past(counterValue_reg <
         compareShadow_reg[0]);
   endproperty
   a_pwm1_up: assert property (p_pwm1_up)
      else $error("pwm1 up level wrong");
   property p_preload_off;
      !preloadEn[0] && writeFire && avs_address == `ADDR_COMPARE1 |=>
         compareShadow_reg[0] == $past(wEff[CNT_W-1:0]);
   endproperty
   a_preload_off: assert property (p_preload_off)
      else $error("compare write not immediate");
   c_pwm_input: cover property (captureEvt[0] ##[1:1000] captureEvt[1]);
   c_match_irq: cover property (matchEvt[0] ##2 channelIrq[0]);
   c_center_wrap: cover property (wrap && centerAlign_reg != 2'h0);
endmodule

/* File: pkg/timer_compare_pwm_channels_cfg.svh */
// Register map, field positions and reset values of the timer channels.
// Assumes byte addresses on a 32-bit Avalon-MM slave.
`ifndef TIMER_COMPARE_PWM_CHANNELS_CFG_SVH
`define TIMER_COMPARE_PWM_CHANNELS_CFG_SVH
`define ADDR_CTRL 6'h00
`define ADDR_SLAVE 6'h04
`define ADDR_EVENT 6'h08
`define ADDR_STATUS 6'h0c
`define ADDR_INTEN 6'h10
`define ADDR_MODE 6'h14
`define ADDR_OUTCFG 6'h18
`define ADDR_COUNTER 6'h1c
`define ADDR_PERIOD 6'h20
`define ADDR_REPEAT 6'h24
`define ADDR_COMPARE1 6'h28
`define ADDR_COMPARE2 6'h2c
`define CTRL_ENABLE_BIT 0
`define CTRL_DIR_BIT 1
`define CTRL_CENTER_LSB 2
`define CTRL_RELOAD_PRE_BIT 4
`define SLAVE_MODE_LSB 0
`define SLAVE_TRIG_LSB 4
`define EVENT_UPDATE_BIT 0
`define MODE_STRIDE 8
`define MODE_ROLE_LSB 0
`define MODE_PRELOAD_BIT 3
`define MODE_OCM_LSB 4
`define OUTCFG_STRIDE 4
`define OUTCFG_EN_BIT 0
`define OUTCFG_POL_BIT 1
`define SLAVE_MODE_RESET 3'h4
`define TRIG_FILTERED_IN1 3'h5
`define CENTER_DOWN_ONLY 2'h1
`define CENTER_UP_ONLY 2'h2
`define CENTER_BOTH 2'h3
`define PERIOD_RESET 16'hffff
`endif

/* File: pkg/timer_pwm_pkg.sv */
// Types shared by the timer channel logic.
// Assumes nothing of its surroundings.
package timer_pwm_pkg;
   typedef enum logic [2:0] {
      CMP_FROZEN = 3'h0,
      CMP_SET_ACTIVE = 3'h1,
      CMP_SET_INACTIVE = 3'h2,
      CMP_TOGGLE = 3'h3,
      CMP_FORCE_LOW = 3'h4,
      CMP_FORCE_HIGH = 3'h5,
      CMP_PWM1 = 3'h6,
      CMP_PWM2 = 3'h7
   } compare_mode_t;
   typedef enum logic [1:0] {
      ROLE_OUTPUT = 2'h0,
      ROLE_DIRECT = 2'h1,
      ROLE_CROSS = 2'h2,
      ROLE_SPARE = 2'h3
   } channel_role_t;
   typedef logic [1:0] chan_pair_t;
endpackage

/* File: tb/pwm_source.sv */
// Far-side model: a square-wave source on timer input 1.
// Assumes the bench raises run once the channels are set up.
module pwm_source #(
   parameter int HIGH_CYC = 7,
   parameter int LOW_CYC = 13
) (
   input wire logic sys_clk,
   input wire logic run,
   input wire timer_pwm_pkg::chan_pair_t compare_output_pin,
   output timer_pwm_pkg::chan_pair_t timer_input
);
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pwm_pkg::*;
   int phase = 0;
   // One pin carries both edges for the two capture paths
   always_ff @(posedge sys_clk)
   begin
      if (!run)
      begin
         phase <= 0;
         timer_input <= 2'h0;
      end
      else
      begin
         phase <= (phase == HIGH_CYC + LOW_CYC - 1) ? 0 : phase + 1;
         timer_input <= {1'b0, phase < HIGH_CYC}; // Input 2 idles low
      end
   end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the timer channels, driven over Avalon-MM.
// Assumes the register map header and the square-wave source model.
`include "timer_compare_pwm_channels_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pwm_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic run = 1'b0;
   chan_pair_t timer_input;
   chan_pair_t compare_output_pin;
   chan_pair_t channelIrq;
   logic [31:0] rd;
   int bad_count = 0;
   int n_checks = 0;
   int highs;
   int md[8] = '{1, 0, 2, 3, 6, 7, 6, 6};
   int cv[8] = '{3, 3, 3, 3, 3, 3, 0, 12};
   int ex[8] = '{20, 20, 0, 10, 6, 14, 0, 20};

   timer_compare_pwm_channels timer_compare_pwm_channels_inst (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .timer_input(timer_input),
      .compare_output_pin(compare_output_pin),
      .channelIrq(channelIrq)
   );
   pwm_source pwm_source_inst (.sys_clk(sys_clk), .run(run),
      .compare_output_pin(compare_output_pin), .timer_input(timer_input));

   // Free-running 250 MHz clock
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Value must lie in lo..hi; an unknown never matches
   task automatic check(input string what, input logic [31:0] lo,
      input logic [31:0] hi, input logic [31:0] got);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, lo, got);
      end
   endtask

   // One Avalon access; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] addr,
      input logic [31:0] data);
      int n;
      n = 0;
      avs_address <= addr;
      avs_writedata <= data;
      avs_read <= !wr;
      avs_write <= wr;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         bad_count++;
         end_of_test();
      end
      else
      begin
         rd = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge sys_clk); // Let one edge pass before the next request
      end
   endtask

   task automatic wr(input logic [5:0] addr, input logic [31:0] data);
      bus(1'b1, addr, data);
   endtask

   task automatic rdchk(input logic [5:0] addr, input logic [31:0] lo,
      input logic [31:0] hi, input string what);
      bus(1'b0, addr, 32'h0);
      check(what, lo, hi, rd);
   endtask

   // Counts high cycles of pin 1 after a full period and the pipeline settle
   task automatic count_high(input int cycles);
      highs = 0;
      repeat (13) @(posedge sys_clk);
      repeat (cycles)
      begin
         @(negedge sys_clk);
         highs += (compare_output_pin[0] === 1'b1);
      end
      @(posedge sys_clk);
   endtask

   // Main sequence
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rdchk(`ADDR_MODE, 32'h0, 32'h0, "mode");
      rdchk(`ADDR_OUTCFG, 32'h0, 32'h0, "outcfg");
      rdchk(`ADDR_PERIOD, 32'hffff, 32'hffff, "period");
      rdchk(6'h30, 32'h0, 32'h0, "unmapped");
      check("pins", 32'h0, 32'h0, {30'h0, compare_output_pin});
      $display("test reset done");
      wr(`ADDR_REPEAT, 32'hff);
      wr(`ADDR_PERIOD, 32'h9);
      wr(`ADDR_COMPARE1, 32'h3);
      wr(`ADDR_OUTCFG, 32'h1);
      wr(`ADDR_INTEN, 32'h1);
      wr(`ADDR_MODE, 32'h50);
      wr(`ADDR_CTRL, 32'h1);
      count_high(20);
      check("force high", 20, 20, highs);
      rdchk(`ADDR_STATUS, 32'h3, 32'h3, "match flags");
      check("irq", 1, 1, {31'h0, channelIrq[0]});
      wr(`ADDR_OUTCFG, 32'h3);
      count_high(20);
      check("inverted", 0, 0, highs);
      wr(`ADDR_OUTCFG, 32'h1);
      wr(`ADDR_MODE, 32'h40);
      count_high(20);
      check("force low", 0, 0, highs);
      $display("test forced done");
      for (int i = 0; i < 8; i++)
      begin
         wr(`ADDR_MODE, 32'(md[i]) << 4);
         wr(`ADDR_COMPARE1, 32'(cv[i]));
         count_high(20);
         check("duty", ex[i], ex[i], highs);
      end
      $display("test compare modes done");
      wr(`ADDR_MODE, 32'h68);
      wr(`ADDR_EVENT, 32'h1);
      wr(`ADDR_COMPARE1, 32'h5);
      count_high(20);
      check("preload held", 0, 0, highs);
      wr(`ADDR_EVENT, 32'h1);
      count_high(20);
      check("preload loaded", 10, 10, highs);
      $display("test preload done");
      wr(`ADDR_PERIOD, 32'hffff);
      wr(`ADDR_MODE, 32'h201);
      wr(`ADDR_OUTCFG, 32'h31);
      wr(`ADDR_SLAVE, 32'h54);
      run <= 1'b1;
      repeat (100) @(posedge sys_clk);
      rdchk(`ADDR_COMPARE1, 19, 21, "period capture");
      rdchk(`ADDR_COMPARE2, 6, 8, "high capture");
      $display("test pwm input done");
      end_of_test();
   end
endmodule
